//--- inc/sfb_params.svh
// constants for the status flags and bank select block
// How it works
// - bank toggle command followed by data 0x53 flips the active bank.
// - status bit 7 shows the active bank, 0 or 1.
// - bit 6 sets when a new payload enters the receive FIFO; resets 0.
// - receive-ready flag clears only on a written one; zero leaves it.
// - bit 5 sets when a packet has been transmitted; resets 0.
// - with auto acknowledge on, data-sent waits for the acknowledgement.
// - data-sent flag clears on a written one; zero has no effect.
// - bit 4 sets when retransmits run out without success; resets 0.
// - retransmit-limit flag clears on a written one; link held off till then.
// - status register shifts out on the data output during the command byte.
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH
`define SFB_BIT_BANK 3'd7
`define SFB_BIT_RXDR 3'd6
`define SFB_BIT_DS 3'd5
`define SFB_BIT_RT 3'd4
`define SFB_STATUS_RST 8'h00
`define SFB_CMD_WR_STATUS 8'h27
`define SFB_CMD_BANK_TOGGLE 8'h50
`define SFB_BANK_KEY 8'h53
`define SFB_BITS_PER_BYTE 4'h8
`define SFB_BITS_PER_WORD 5'h10
`define SFB_CNT_ZERO 5'h00
`define SFB_CNT_ONE 5'h01
`endif

//--- inc/sfb_pkg.sv
// types for the status flags and bank select block
package sfb_pkg;
  typedef struct packed {
    logic bank_indicator;
    logic rx_data_ready_flag;
    logic data_sent_flag;
    logic retransmit_limit_flag;
    logic [3:0] low_fields;
  } sfb_status_t;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } sfb_spi_word_t;
  typedef struct packed {
    logic rx_payload_written;
    logic tx_packet_done;
    logic ack_received;
    logic retransmit_exhausted;
  } sfb_events_t;
endpackage

//--- rtl/sfb_status_flags.sv
// status register flags, bank indicator and serial status port
`timescale 1ns/1ps
`include "sfb_params.svh"
module sfb_status_flags (
  input wire logic mclk,
  input wire logic rst_b,
  input wire sfb_pkg::sfb_events_t events,
  input wire logic auto_ack_en,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output sfb_pkg::sfb_status_t event_status,
  output logic comm_suspend
);

  // ---------------- link side, on spi_sclk ----------------
  // mode 1 framing: output changes on rising edge, input sampled on falling.
  // counters restart whenever chip select is high, so no edge is needed
  // after a frame for them to be ready for the next one.
  logic [4:0] in_cnt_r;
  logic [4:0] in_cnt_nxt;
  logic [15:0] in_sh_r;
  logic [15:0] in_sh_nxt;
  sfb_pkg::sfb_spi_word_t word_r;
  sfb_pkg::sfb_spi_word_t word_nxt;
  logic word_tog_r;
  logic word_tog_nxt;
  logic [4:0] out_cnt_r;
  logic [4:0] out_cnt_nxt;
  logic miso_r;
  logic miso_nxt;
  sfb_pkg::sfb_status_t shadow_r;

  always_comb begin
    in_cnt_nxt = in_cnt_r;
    in_sh_nxt = {in_sh_r[14:0], spi_mosi};
    word_nxt = word_r;
    word_tog_nxt = word_tog_r;
    if (in_cnt_r != `SFB_BITS_PER_WORD) begin
      in_cnt_nxt = in_cnt_r + `SFB_CNT_ONE;
    end
    if (in_cnt_r == `SFB_BITS_PER_WORD - `SFB_CNT_ONE) begin
      // command plus data byte complete: hand the word over
      word_nxt = in_sh_nxt;
      word_tog_nxt = ~word_tog_r;
    end
  end

  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      in_cnt_r <= `SFB_CNT_ZERO;
      in_sh_r <= 16'h0000;
    end else begin
      in_cnt_r <= in_cnt_nxt;
      in_sh_r <= in_sh_nxt;
    end
  end

  // word and toggle must survive chip select, the core reads them later
  always_ff @(negedge spi_sclk) begin
    word_r <= word_nxt;
  end

  // toggle needs a known start or the core never sees a word arrive;
  // the link clock idles during reset, so no edge races the release
  always_ff @(negedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      word_tog_r <= 1'b0;
    end else begin
      word_tog_r <= word_tog_nxt;
    end
  end

  always_comb begin
    out_cnt_nxt = out_cnt_r;
    miso_nxt = 1'b0;
    if (out_cnt_r < {1'b0, `SFB_BITS_PER_BYTE}) begin
      // shadow is frozen by the core for the whole frame
      miso_nxt = shadow_r[3'h7 - out_cnt_r[2:0]];
      out_cnt_nxt = out_cnt_r + `SFB_CNT_ONE;
    end
  end

  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      out_cnt_r <= `SFB_CNT_ZERO;
      miso_r <= 1'b0;
    end else begin
      out_cnt_r <= out_cnt_nxt;
      miso_r <= miso_nxt;
    end
  end

  assign spi_miso = miso_r;

  // ---------------- core side, on mclk ----------------
  logic [2:0] cs_sync_r;
  logic [2:0] cs_sync_nxt;
  logic [2:0] tog_sync_r;
  logic [2:0] tog_sync_nxt;
  logic frame_r;
  logic frame_nxt;
  logic tog_seen_r;
  logic tog_seen_nxt;
  sfb_pkg::sfb_status_t status_r;
  sfb_pkg::sfb_status_t status_nxt;
  sfb_pkg::sfb_status_t shadow_nxt;
  logic suspend_r;
  logic suspend_nxt;
  logic word_evt;
  logic [7:0] clr_mask;
  logic set_rx;
  logic set_ds;
  logic set_rt;

  always_comb begin
    cs_sync_nxt = {cs_sync_r[1:0], spi_cs_n};
    tog_sync_nxt = {tog_sync_r[1:0], word_tog_r};
    frame_nxt = frame_r;
    tog_seen_nxt = tog_seen_r;
    word_evt = 1'b0;
    // a change counts once the second and third stages agree
    if (cs_sync_r[1] == cs_sync_r[2]) begin
      frame_nxt = ~cs_sync_r[2];
    end
    if (tog_sync_r[1] == tog_sync_r[2] && tog_sync_r[2] != tog_seen_r) begin
      tog_seen_nxt = tog_sync_r[2];
      word_evt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cs_sync_r <= 3'h7;
      tog_sync_r <= 3'h0;
      frame_r <= 1'b0;
      tog_seen_r <= 1'b0;
    end else begin
      cs_sync_r <= cs_sync_nxt;
      tog_sync_r <= tog_sync_nxt;
      frame_r <= frame_nxt;
      tog_seen_r <= tog_seen_nxt;
    end
  end

  always_comb begin
    status_nxt = status_r;
    clr_mask = 8'h00;
    set_rx = events.rx_payload_written;
    set_ds = auto_ack_en ? events.ack_received
                         : events.tx_packet_done;
    set_rt = events.retransmit_exhausted;
    if (word_evt) begin
      if (word_r.cmd == `SFB_CMD_WR_STATUS) begin
        clr_mask = word_r.data;
      end
      if (word_r.cmd == `SFB_CMD_BANK_TOGGLE &&
          word_r.data == `SFB_BANK_KEY) begin
        status_nxt.bank_indicator = ~status_r.bank_indicator;
      end
    end
    // set wins over a clear landing in the same cycle
    status_nxt.rx_data_ready_flag = set_rx |
      (status_r.rx_data_ready_flag & ~clr_mask[`SFB_BIT_RXDR]);
    status_nxt.data_sent_flag = set_ds |
      (status_r.data_sent_flag & ~clr_mask[`SFB_BIT_DS]);
    status_nxt.retransmit_limit_flag = set_rt |
      (status_r.retransmit_limit_flag & ~clr_mask[`SFB_BIT_RT]);
    status_nxt.low_fields = 4'h0;
    suspend_nxt = status_nxt.retransmit_limit_flag;
    // shadow only moves outside a frame, so the link side reads it stable
    shadow_nxt = frame_r ? shadow_r : status_r;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      status_r <= `SFB_STATUS_RST;
      shadow_r <= `SFB_STATUS_RST;
      suspend_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      shadow_r <= shadow_nxt;
      suspend_r <= suspend_nxt;
    end
  end

  assign event_status = status_r;
  assign comm_suspend = suspend_r;

endmodule

//--- testbench/sfb_status_flags_asserts.sv
// assertions for the status flags block
`timescale 1ns/1ps
module sfb_status_flags_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire sfb_pkg::sfb_events_t events,
  input wire logic auto_ack_en,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire sfb_pkg::sfb_status_t event_status,
  input wire logic comm_suspend
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_rx; events.rx_payload_written |=> event_status[6]; endproperty
  a_rx: assert property (p_rx) else $error("rx flag");
  property p_ds; events.tx_packet_done && !auto_ack_en |=> event_status[5];
  endproperty
  a_ds: assert property (p_ds) else $error("sent flag");
  property p_ack; events.ack_received && auto_ack_en |=> event_status[5];
  endproperty
  a_ack: assert property (p_ack) else $error("ack flag");
  property p_why; $rose(event_status[5]) |-> $past(auto_ack_en ?
    events.ack_received : events.tx_packet_done); endproperty
  a_why: assert property (p_why) else $error("sent cause");
  property p_rt; events.retransmit_exhausted |=> event_status[4]; endproperty
  a_rt: assert property (p_rt) else $error("limit flag");
  property p_sus; comm_suspend == event_status[4]; endproperty
  a_sus: assert property (p_sus) else $error("suspend");
  property p_keep; $fell(event_status[6]) |->
    !$past(events.rx_payload_written); endproperty
  a_keep: assert property (p_keep) else $error("set lost");
  property p_miso; spi_cs_n |-> !spi_miso; endproperty
  a_miso: assert property (p_miso) else $error("miso idle");
endmodule
bind sfb_status_flags sfb_status_flags_asserts u_chk (.mclk, .rst_b,
  .events, .auto_ack_en, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
  .event_status, .comm_suspend);

//--- testbench/sfb_spi_host.sv
// host side of the serial status port
`timescale 1ns/1ps
module sfb_spi_host (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // mode 1 frame; status byte taken on falling edges
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    spi_cs_n = 1'b0;
    #30;
    for (int i = 15; i >= 0; i--) begin
      spi_sclk = 1'b1;
      spi_mosi = w[i];
      #7.5;
      spi_sclk = 1'b0;
      if (i > 7) rd[i-8] = spi_miso;
      #7.5;
    end
    #30;
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the status flags block
`timescale 1ns/1ps
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module testbench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic auto_ack_en = 1'b0;
  sfb_pkg::sfb_events_t events = '0;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, comm_suspend;
  sfb_pkg::sfb_status_t event_status;
  int bad_count = 0;
  int n_tests = 0;
  always #2.5 mclk = ~mclk;
  sfb_status_flags dut (.mclk, .rst_b, .events, .auto_ack_en, .spi_sclk,
    .spi_cs_n, .spi_mosi, .spi_miso, .event_status, .comm_suspend);
  sfb_spi_host host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
  task automatic end_of_test;
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ev(input logic [3:0] v);
    @(posedge mclk) events <= v;
    @(posedge mclk) events <= 4'h0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic spi(input logic [7:0] c, d, rx, st);
    logic [7:0] rd;
    host.xfer({c, d}, rd);
    repeat (10) @(negedge mclk);
    `CHK(rd, rx)
    `CHK(event_status, st)
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
    `CHK(event_status, 8'h00)
    ev(4'h8);
    spi(8'h27, 8'h00, 8'h40, 8'h40);
    spi(8'h27, 8'h40, 8'h40, 8'h00);
    ev(4'h2);
    `CHK(event_status, 8'h00)
    ev(4'h4);
    spi(8'h27, 8'h20, 8'h20, 8'h00);
    auto_ack_en <= 1'b1;
    ev(4'h4);
    `CHK(event_status, 8'h00)
    ev(4'h2);
    spi(8'h27, 8'h00, 8'h20, 8'h20);
    spi(8'h27, 8'h20, 8'h20, 8'h00);
    ev(4'h1);
    `CHK(comm_suspend, 1'b1)
    spi(8'h27, 8'h70, 8'h10, 8'h00);
    spi(8'h50, 8'h52, 8'h00, 8'h00);
    spi(8'h50, 8'h53, 8'h00, 8'h80);
    spi(8'h27, 8'hF0, 8'h80, 8'h80);
    spi(8'h50, 8'h53, 8'h80, 8'h00);
    end_of_test;
  end
  initial begin
    #100000;
    bad_count++;
    end_of_test;
  end
endmodule
